// ==== bench/mcr_host_model.sv ====
`timescale 1ns/100ps
// Host side of the register port; it drives 1 ns after each rising edge
module mcr_host_model (
   input wire logic mclk,
   output logic [5:0] reg_addr,
   output logic reg_wr,
   output logic [23:0] reg_wdata,
   output logic reg_rd,
   input wire logic [23:0] reg_rdata,
   input wire logic reg_rd_valid
);
   // Quiet port at time zero
   initial begin
      reg_addr = 6'h00;
      reg_wdata = 24'h000000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   // One write strobe; stays up until the next access or idle
   task automatic wr(input logic [5:0] a, input logic [23:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_rd = 1'b0;
      reg_wr = 1'b1;
      @(posedge mclk);
      #1;
   endtask

   // One read strobe; data taken with the valid flag, bounded wait
   task automatic rd(input logic [5:0] a, output logic [23:0] d, output logic ok);
      reg_addr = a;
      reg_wr = 1'b0;
      reg_rd = 1'b1;
      ok = 1'b0;
      d = 24'h000000;
      @(posedge mclk);
      #1;
      for (int i = 0; i < 4 && !ok; i++) begin
         if (reg_rd_valid === 1'b1) begin
            d = reg_rdata;
            ok = 1'b1;
         end else begin
            reg_rd = 1'b0;
            @(posedge mclk);
            #1;
         end
      end
   endtask

   // Release strobes; address and data no longer hold their last value
   task automatic idle();
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~reg_addr;
      reg_wdata = ~reg_wdata;
      @(posedge mclk);
      #1;
   endtask
endmodule

// ==== bench/tb_meter_calibration_register_tail.sv ====
`timescale 1ns/100ps
module tb_meter_calibration_register_tail;
   localparam logic [7:0] REV = 8'h5a; // Arbitrary revision code
   logic mclk, rst_n, ce, reg_wr, reg_rd, reg_rd_valid, ok;
   logic [5:0] reg_addr, a;
   logic [23:0] reg_wdata, lower_rdata, reg_rdata, rdat, last;
   logic [3:0][11:0] rms_offset;
   logic [2:0][11:0] active_gain, vrms_gain;
   logic [11:0] exp_cal [10];
   logic [31:0] lfsr;
   int n_mismatch, n_tests;

   mcr_cal_regs #(.CAL_W(12), .REVISION(REV)) u_dut (.mclk(mclk), .rst_n(rst_n), .ce(ce),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
      .lower_rdata(lower_rdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
      .rms_offset(rms_offset), .active_gain(active_gain), .vrms_gain(vrms_gain));
   mcr_host_model u_host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_rd_valid(reg_rd_valid));

   // Free-running clock
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // Random source and expected read word
   function automatic logic [31:0] step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [23:0] expect_rd(input logic [5:0] x);
      if (x < 6'h31) return lower_rdata;
      if (x <= 6'h3a) return {12'h000, exp_cal[x - 6'h31]};
      if (x == 6'h3e) return {16'h0000, 8'($countones(last))};
      if (x == 6'h3f) return {16'h0000, REV};
      return 24'h000000;
   endfunction

   // Comparison, access and verdict helpers
   task automatic check(input string nm, input logic [23:0] e, input logic [23:0] s);
      n_tests++;
      if (s !== e) begin
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
         n_mismatch++;
      end
   endtask
   task automatic give_verdict();
      if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic rd_chk(input logic [5:0] x);
      u_host.rd(x, rdat, ok);
      if (!ok) begin
         n_mismatch++;
         give_verdict();
      end
      check("reg_rdata", expect_rd(x), rdat);
      last = rdat;
   endtask
   task automatic wr_m(input logic [5:0] x, input logic [23:0] d);
      u_host.wr(x, d);
      if (ce && x >= 6'h31 && x <= 6'h3a) exp_cal[x - 6'h31] = d[11:0];
   endtask
   task automatic check_outs();
      logic [119:0] o;
      o = {vrms_gain, active_gain, rms_offset};
      for (int i = 0; i < 10; i++) check("cal_out", {12'h000, exp_cal[i]}, {12'h000, o[i*12 +: 12]});
   endtask

   // Main sequence
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      lower_rdata = 24'h000000;
      lfsr = 32'h5859;
      last = 24'h000000;
      n_mismatch = 0;
      n_tests = 0;
      foreach (exp_cal[i]) exp_cal[i] = 12'h000;
      repeat (4) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      // Reset values, reserved hole and revision, read back to back
      for (int i = 6'h31; i <= 6'h3f; i++) rd_chk(6'(i));
      check_outs();
      // Random back-to-back writes over all calibration registers, then readback
      repeat (40) begin
         lfsr = step(lfsr);
         wr_m(6'h31 + 6'(lfsr[7:0] % 10), lfsr[31:8]);
      end
      u_host.idle();
      for (int i = 6'h31; i <= 6'h3a; i++) rd_chk(6'(i));
      check_outs();
      // Writes to reserved, read-only and lower places change nothing
      for (int i = 6'h3b; i <= 6'h3f; i++) wr_m(6'(i), 24'hffffff);
      wr_m(6'h05, 24'h000fff);
      ce = 1'b0;
      wr_m(6'h35, 24'h000abc);
      u_host.idle();
      ce = 1'b1;
      check_outs();
      for (int i = 6'h3b; i <= 6'h3f; i++) rd_chk(6'(i));
      // Reset in mid-run clears calibration, read data and checksum
      u_host.idle();
      rst_n = 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      foreach (exp_cal[i]) exp_cal[i] = 12'h000;
      last = 24'h000000;
      check_outs();
      check("rdata_rst", 24'h000000, reg_rdata);
      check("rd_valid_rst", 24'h000000, {23'h000000, reg_rd_valid});
      rd_chk(6'h3e);
      // Each register written, then read on the very next cycle
      for (int i = 6'h31; i <= 6'h3a; i++) begin
         lfsr = step(lfsr);
         wr_m(6'(i), lfsr[31:8]);
         rd_chk(6'(i));
      end
      check_outs();
      // Ones count follows every read, any address
      repeat (30) begin
         lfsr = step(lfsr);
         lower_rdata = lfsr[31:8];
         a = lfsr[5:0];
         rd_chk(a);
         u_host.idle();
         rd_chk(6'h3e);
         u_host.idle();
      end
      give_verdict();
   end
endmodule

// ==== design/mcr_cal_regs.sv ====
`timescale 1ns/100ps
// Functional notes
// - Checksum holds ones count of last read
// - Three 12-bit active power gain registers
// - Three 12-bit voltage rms gain registers
// - Four 12-bit rms offsets, reset to zero
// - Read-only ignore writes; read-write take both
module mcr_cal_regs #(
   parameter int CAL_W = 12,
   parameter logic [7:0] REVISION = 8'h5a // Arbitrary value
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [5:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [23:0] reg_wdata,
   input wire logic reg_rd,
   input wire logic [23:0] lower_rdata,
   output logic [23:0] reg_rdata,
   output logic reg_rd_valid,
   output logic [3:0][CAL_W-1:0] rms_offset,
   output logic [2:0][CAL_W-1:0] active_gain,
   output logic [2:0][CAL_W-1:0] vrms_gain
);
   localparam int PAD_W = mcr_pkg::DATA_W - CAL_W;

   mcr_rd_if rd ();

   logic [CAL_W-1:0] cal_q [mcr_pkg::CAL_N];
   logic [23:0] rdata_q;
   logic rd_valid_q;

   // Address decode
   wire logic cal_hit = mcr_pkg::is_cal(reg_addr);
   wire logic rsv_hit = mcr_pkg::is_rsv(reg_addr);
   wire logic ones_hit = (reg_addr == mcr_pkg::ADDR_READ_ONES_COUNT);
   wire logic rev_hit = (reg_addr == mcr_pkg::ADDR_DIE_REVISION);
   wire logic lower_hit = (reg_addr < mcr_pkg::ADDR_C_CURRENT_RMS_OFFSET);
   wire logic [3:0] cal_idx = mcr_pkg::cal_index(reg_addr);
   wire logic cal_wr = ce && reg_wr && cal_hit;
   wire logic rd_take = ce && reg_rd;

   // Read data selection
   wire logic [23:0] cal_word = {{PAD_W{1'b0}}, cal_q[cal_idx]};
   wire logic [23:0] ones_word = {16'h0000, rd.ones_q};
   wire logic [23:0] rev_word = {16'h0000, REVISION};
   wire logic [23:0] rd_mux =
      cal_hit ? cal_word :
      ones_hit ? ones_word :
      rev_hit ? rev_word :
      lower_hit ? lower_rdata :
      mcr_pkg::DATA_RESET;

   // Every read leaving the port feeds the checksum
   assign rd.rd_fire = rd_take;
   assign rd.rd_word = rd_mux;

   mcr_ones_count u_ones (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .rd(rd.counter)
   );

   // Calibration storage; only this range holds writable state
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         for (int i = 0; i < mcr_pkg::CAL_N; i++) begin
            cal_q[i] <= mcr_pkg::CAL_RESET[CAL_W-1:0];
         end
      end else if (cal_wr) begin
         cal_q[cal_idx] <= reg_wdata[CAL_W-1:0];
      end
   end

   // Read answer, one cycle after the request
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rdata_q <= mcr_pkg::DATA_RESET;
         rd_valid_q <= 1'b0;
      end else if (ce) begin
         rd_valid_q <= rd_take;
         if (rd_take) begin
            rdata_q <= rd_mux;
         end
      end
   end

   assign reg_rdata = rdata_q;
   assign reg_rd_valid = rd_valid_q;

   // Calibration values toward the metering datapath
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_off
         assign rms_offset[g] = cal_q[32'(mcr_pkg::IDX_RMS_OFFSET) + g];
      end
      for (g = 0; g < 3; g++) begin : g_gain
         assign active_gain[g] = cal_q[32'(mcr_pkg::IDX_ACTIVE_GAIN) + g];
         assign vrms_gain[g] = cal_q[32'(mcr_pkg::IDX_VRMS_GAIN) + g];
      end
   endgenerate

   // Flat view of all calibration storage for checks
   wire logic [10*CAL_W-1:0] cal_flat = {vrms_gain, active_gain, rms_offset};

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   // Read steps
   sequence s_read_any;
      ce && reg_rd;
   endsequence

   sequence s_read_ones;
      ce && reg_rd && (reg_addr == mcr_pkg::ADDR_READ_ONES_COUNT);
   endsequence

   // Checksum read returns the ones of the previous read word
   property p_checksum;
      s_read_any ##1 s_read_ones |=>
         (reg_rdata == 24'($countones($past(reg_rdata))));
   endproperty
   AST_CHECKSUM: assert property (p_checksum) else $error("checksum mismatch");

   // Active power gain write lands in its output
   property p_active_gain_wr;
      (cal_wr && (reg_addr >= mcr_pkg::ADDR_A_ACTIVE_POWER_GAIN)
         && (reg_addr <= mcr_pkg::ADDR_C_ACTIVE_POWER_GAIN)) |=>
         (active_gain[$past(cal_idx) - mcr_pkg::IDX_ACTIVE_GAIN] ==
          $past(reg_wdata[CAL_W-1:0]));
   endproperty
   AST_ACTIVE_GAIN_WR: assert property (p_active_gain_wr) else $error("gain write lost");

   // Voltage rms gain write lands, then reads back
   property p_vrms_gain_rb;
      (cal_wr && (reg_addr >= mcr_pkg::ADDR_A_VOLTAGE_RMS_GAIN)) ##1
         (ce && reg_rd && !reg_wr && (reg_addr == $past(reg_addr))) |=>
         (reg_rdata == {{PAD_W{1'b0}}, $past(reg_wdata[CAL_W-1:0], 2)});
   endproperty
   AST_VRMS_GAIN_RB: assert property (p_vrms_gain_rb) else $error("vrms gain readback");

   // Calibration comes out of reset at zero; a write may follow at once
   property p_offset_reset;
      $rose(rst_n) |-> (rms_offset == '0) && (active_gain == '0) && (vrms_gain == '0);
   endproperty
   AST_OFFSET_RESET: assert property (@(posedge mclk) p_offset_reset)
      else $error("offset not zero");

   // Writes outside the calibration range change nothing
   property p_ro_ignore;
      (ce && reg_wr && !cal_hit) |=> $stable(cal_flat);
   endproperty
   AST_RO_IGNORE: assert property (p_ro_ignore) else $error("read-only write took");

   // Revision reads back its fixed value
   property p_revision;
      (ce && reg_rd && rev_hit) |=> reg_rd_valid && (reg_rdata == {16'h0000, REVISION});
   endproperty
   AST_REVISION: assert property (p_revision) else $error("revision wrong");

   // Reserved hole reads zero
   property p_rsv_zero;
      (ce && reg_rd && rsv_hit) |=> reg_rd_valid && (reg_rdata == mcr_pkg::DATA_RESET);
   endproperty
   AST_RSV_ZERO: assert property (p_rsv_zero) else $error("reserved read nonzero");

   // Storage holds while no calibration write comes
   property p_cal_hold;
      !cal_wr |=> $stable(cal_flat);
   endproperty
   AST_CAL_HOLD: assert property (p_cal_hold) else $error("calibration drifted");

   // Valid pulses once per accepted read
   property p_valid;
      ce |=> (reg_rd_valid == $past(reg_rd));
   endproperty
   AST_VALID: assert property (p_valid) else $error("valid mismatch");

   // Offset write lands in its output
   property p_offset_wr;
      (cal_wr && (reg_addr <= mcr_pkg::ADDR_C_VOLTAGE_RMS_OFFSET)) |=>
         (rms_offset[$past(cal_idx)] == $past(reg_wdata[CAL_W-1:0]));
   endproperty
   AST_OFFSET_WR: assert property (p_offset_wr) else $error("offset write lost");

   // Voltage rms gain write lands in its output
   property p_vrms_gain_wr;
      (cal_wr && (reg_addr >= mcr_pkg::ADDR_A_VOLTAGE_RMS_GAIN)) |=>
         (vrms_gain[$past(cal_idx) - mcr_pkg::IDX_VRMS_GAIN] ==
          $past(reg_wdata[CAL_W-1:0]));
   endproperty
   AST_VRMS_GAIN_WR: assert property (p_vrms_gain_wr) else $error("vrms write lost");

   // Calibration read returns the stored word, upper bits zero
   property p_cal_read;
      (ce && reg_rd && cal_hit) |=> reg_rd_valid &&
         (reg_rdata == {{PAD_W{1'b0}}, $past(cal_flat[cal_idx*CAL_W +: CAL_W])});
   endproperty
   AST_CAL_READ: assert property (p_cal_read) else $error("cal read wrong");

   // Lower map read passes its word through to the read data
   property p_lower_read;
      (ce && reg_rd && lower_hit) |=> reg_rd_valid && (reg_rdata == $past(lower_rdata));
   endproperty
   AST_LOWER_READ: assert property (p_lower_read) else $error("lower read wrong");

   // Read data holds until the next accepted read
   property p_rdata_hold;
      !(ce && reg_rd) |=> $stable(reg_rdata);
   endproperty
   AST_RDATA_HOLD: assert property (p_rdata_hold) else $error("read data moved");

   // Clock enable low freezes every register
   property p_ce_freeze;
      !ce |=> $stable(cal_flat) && $stable(reg_rdata) &&
         $stable(reg_rd_valid) && $stable(rd.ones_q);
   endproperty
   AST_CE_FREEZE: assert property (p_ce_freeze) else $error("state moved, ce low");

   // Writes to the checksum and revision leave the count alone
   property p_ro_write;
      (ce && reg_wr && !reg_rd && (ones_hit || rev_hit)) |=> $stable(rd.ones_q);
   endproperty
   AST_RO_WRITE: assert property (p_ro_write) else $error("count took a write");
endmodule

// ==== design/mcr_ones_count.sv ====
`timescale 1ns/100ps
module mcr_ones_count (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   mcr_rd_if.counter rd
);
   // Population count of a read word
   function automatic logic [7:0] ones_of(input logic [23:0] word);
      logic [7:0] n;
      n = 8'h00;
      for (int i = 0; i < mcr_pkg::DATA_W; i++) begin
         n = n + {7'h00, word[i]};
      end
      return n;
   endfunction

   // Checksum follows every read sent out
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rd.ones_q <= mcr_pkg::ONES_RESET;
      end else if (ce && rd.rd_fire) begin
         rd.ones_q <= ones_of(rd.rd_word);
      end
   end

   // Count lands one cycle after the read
   property p_ones_track;
      @(posedge mclk) disable iff (!rst_n)
         (ce && rd.rd_fire) |=> (rd.ones_q == ones_of($past(rd.rd_word)));
   endproperty
   AST_ONES_TRACK: assert property (p_ones_track) else $error("ones count wrong");

   // Count holds when no read goes out
   property p_ones_hold;
      @(posedge mclk) disable iff (!rst_n)
         !(ce && rd.rd_fire) |=> $stable(rd.ones_q);
   endproperty
   AST_ONES_HOLD: assert property (p_ones_hold) else $error("ones count moved");
endmodule

// ==== design/mcr_pkg.sv ====
package mcr_pkg;
   // Bus widths and calibration register count
   localparam int ADDR_W = 6;
   localparam int DATA_W = 24;
   localparam int CAL_W = 12;
   localparam int CAL_N = 10;
   localparam int ONES_W = 8;
   localparam int IDX_W = 4;

   // Register addresses
   localparam logic [5:0] ADDR_C_CURRENT_RMS_OFFSET = 6'h31;
   localparam logic [5:0] ADDR_A_VOLTAGE_RMS_OFFSET = 6'h32;
   localparam logic [5:0] ADDR_B_VOLTAGE_RMS_OFFSET = 6'h33;
   localparam logic [5:0] ADDR_C_VOLTAGE_RMS_OFFSET = 6'h34;
   localparam logic [5:0] ADDR_A_ACTIVE_POWER_GAIN = 6'h35;
   localparam logic [5:0] ADDR_B_ACTIVE_POWER_GAIN = 6'h36;
   localparam logic [5:0] ADDR_C_ACTIVE_POWER_GAIN = 6'h37;
   localparam logic [5:0] ADDR_A_VOLTAGE_RMS_GAIN = 6'h38;
   localparam logic [5:0] ADDR_B_VOLTAGE_RMS_GAIN = 6'h39;
   localparam logic [5:0] ADDR_C_VOLTAGE_RMS_GAIN = 6'h3a;
   localparam logic [5:0] ADDR_RSV_FIRST = 6'h3b;
   localparam logic [5:0] ADDR_RSV_LAST = 6'h3d;
   localparam logic [5:0] ADDR_READ_ONES_COUNT = 6'h3e;
   localparam logic [5:0] ADDR_DIE_REVISION = 6'h3f;

   // Index of the first slot of each calibration group
   localparam logic [3:0] IDX_RMS_OFFSET = 4'h0;
   localparam logic [3:0] IDX_ACTIVE_GAIN = 4'h4;
   localparam logic [3:0] IDX_VRMS_GAIN = 4'h7;

   // Values after reset
   localparam logic [11:0] CAL_RESET = 12'h000;
   localparam logic [7:0] ONES_RESET = 8'h00;
   localparam logic [23:0] DATA_RESET = 24'h000000;

   // Cycles from an accepted read to its data
   localparam int READ_LATENCY = 1;

   // Address falls on a calibration register
   function automatic logic is_cal(input logic [5:0] addr);
      return (addr >= ADDR_C_CURRENT_RMS_OFFSET) && (addr <= ADDR_C_VOLTAGE_RMS_GAIN);
   endfunction

   // Address falls in the empty hole
   function automatic logic is_rsv(input logic [5:0] addr);
      return (addr >= ADDR_RSV_FIRST) && (addr <= ADDR_RSV_LAST);
   endfunction

   // Slot of a calibration register in the array
   function automatic logic [3:0] cal_index(input logic [5:0] addr);
      logic [5:0] diff;
      diff = addr - ADDR_C_CURRENT_RMS_OFFSET;
      return diff[3:0];
   endfunction
endpackage

// ==== design/mcr_rd_if.sv ====
`timescale 1ns/100ps
interface mcr_rd_if;
   // One read leaving the port, and the ones count kept for it
   logic rd_fire;
   logic [23:0] rd_word;
   logic [7:0] ones_q;

   modport regs (output rd_fire, output rd_word, input ones_q);
   modport counter (input rd_fire, input rd_word, output ones_q);
endinterface
